// File: ntar_pkg.sv
package ntar_pkg;

  localparam int ADDR_W = 64;

  // apb register byte offsets; low word, then high word of each 64-bit value
  localparam logic [7:0] OFF_NP_PRI_BASE_LO = 8'h00;
  localparam logic [7:0] OFF_NP_PRI_BASE_HI = 8'h04;
  localparam logic [7:0] OFF_NP_PRI_LIM_LO = 8'h08;
  localparam logic [7:0] OFF_NP_PRI_LIM_HI = 8'h0c;
  localparam logic [7:0] OFF_NP_SEC_BASE_LO = 8'h10;
  localparam logic [7:0] OFF_NP_SEC_BASE_HI = 8'h14;
  localparam logic [7:0] OFF_PF_PRI_BASE_LO = 8'h18;
  localparam logic [7:0] OFF_PF_PRI_BASE_HI = 8'h1c;
  localparam logic [7:0] OFF_PF_PRI_LIM_LO = 8'h20;
  localparam logic [7:0] OFF_PF_PRI_LIM_HI = 8'h24;
  localparam logic [7:0] OFF_PF_SEC_BASE_LO = 8'h28;
  localparam logic [7:0] OFF_PF_SEC_BASE_HI = 8'h2c;
  localparam logic [7:0] OFF_UP_PRI_BASE_LO = 8'h30;
  localparam logic [7:0] OFF_UP_PRI_BASE_HI = 8'h34;
  localparam logic [7:0] OFF_UP_SEC_BASE_LO = 8'h38;
  localparam logic [7:0] OFF_UP_SEC_BASE_HI = 8'h3c;
  localparam logic [7:0] OFF_UP_SEC_LIM_LO = 8'h40;
  localparam logic [7:0] OFF_UP_SEC_LIM_HI = 8'h44;
  localparam logic [7:0] OFF_OPQ_BASE_LO = 8'h48;
  localparam logic [7:0] OFF_OPQ_BASE_HI = 8'h4c;
  localparam logic [7:0] OFF_OPQ_LIM_LO = 8'h50;
  localparam logic [7:0] OFF_OPQ_LIM_HI = 8'h54;
  localparam logic [7:0] OFF_CTRL = 8'h58;
  localparam logic [7:0] OFF_IO_REMAP = 8'h5c;
  localparam logic [7:0] OFF_STATUS = 8'h60;
  localparam logic [7:0] OFF_NP_SEC_LIM_LO = 8'h64;
  localparam logic [7:0] OFF_NP_SEC_LIM_HI = 8'h68;
  localparam logic [7:0] OFF_PF_SEC_LIM_LO = 8'h6c;
  localparam logic [7:0] OFF_PF_SEC_LIM_HI = 8'h70;
  localparam logic [7:0] OFF_UP_PRI_LIM_LO = 8'h74;
  localparam logic [7:0] OFF_UP_PRI_LIM_HI = 8'h78;

  // number of 64-bit window values held in the table
  localparam int NUM_WIN = 11;
  localparam int W_NP_PRI_BASE = 0;
  localparam int W_NP_PRI_LIM = 1;
  localparam int W_NP_SEC_BASE = 2;
  localparam int W_PF_PRI_BASE = 3;
  localparam int W_PF_PRI_LIM = 4;
  localparam int W_PF_SEC_BASE = 5;
  localparam int W_UP_PRI_BASE = 6;
  localparam int W_UP_SEC_BASE = 7;
  localparam int W_UP_SEC_LIM = 8;
  localparam int W_OPQ_BASE = 9;
  localparam int W_OPQ_LIM = 10;

  // control register fields
  localparam int CTRL_OPQ_EN_BIT = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [63:0] WIN_RST = 64'h0000_0000_0000_0000;
  localparam logic [4:0] IO_REMAP_RST = 5'h00;
  localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;

  // status register fields
  localparam int ST_IO_ACTIVE_BIT = 0;
  localparam int ST_OPQ_ACTIVE_BIT = 1;

  // one address request and its answer
  typedef struct packed {
    logic valid;
    logic [63:0] addr;
  } ntar_req_t;

  typedef struct packed {
    logic valid;
    logic claim;
    logic [63:0] addr;
  } ntar_rsp_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } ntar_io_req_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
  } ntar_io_rsp_t;

  typedef struct packed {
    logic [NUM_WIN-1:0][63:0] win;
    logic opq_en;
    logic [4:0] io_drop;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [63:0] np_off;
    logic [63:0] pf_off;
    logic [63:0] up_off;
    logic [63:0] np_sec_lim;
    logic [63:0] pf_sec_lim;
    logic [63:0] up_pri_lim;
    ntar_rsp_t up_rsp;
    ntar_rsp_t dn_rsp;
    ntar_io_rsp_t io_rsp;
  } ntar_state_t;

endpackage : ntar_pkg

// File: ntar_remap.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Operation
// - no pci claim inside shifted secondary windows
// - secondary np limit = primary limit minus offset
// - secondary pf limit = primary limit minus offset
// - claimed pci cycle goes upstream via remap window
// - upstream secondary base/limit form pci window
// - offset = primary base minus secondary; limit shifted
// - in-window address plus upstream offset
// - outside window forwarded upstream unchanged
// - io remap drops that many upper bits
// - io remap active whenever setting nonzero
// - opaque range active only when enabled
// - opaque range claimed on neither side
// - downstream np address minus np offset
// - downstream pf address minus pf offset
module ntar_remap (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // pci-side memory cycle going upstream
  input ntar_pkg::ntar_req_t up_req_in,
  output ntar_pkg::ntar_rsp_t up_rsp_out,
  // pcie-side memory cycle going downstream
  input ntar_pkg::ntar_req_t dn_req_in,
  output ntar_pkg::ntar_rsp_t dn_rsp_out,
  // pcie-side io cycle going downstream
  input ntar_pkg::ntar_io_req_t io_req_in,
  output ntar_pkg::ntar_io_rsp_t io_rsp_out
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic in_win(input logic [63:0] a,
                                  input logic [63:0] lo,
                                  input logic [63:0] hi);
    in_win = (a >= lo) && (a <= hi);
  endfunction : in_win

  // maps a byte offset to a window slot; slot NUM_WIN means none
  function automatic logic [4:0] win_slot(input logic [7:0] off);
    logic [4:0] idx;
    idx = 5'(off[7:3]);
    if (off < ntar_pkg::OFF_CTRL && idx < 5'(ntar_pkg::NUM_WIN)) begin
      win_slot = idx;
    end else begin
      win_slot = 5'(ntar_pkg::NUM_WIN);
    end
  endfunction : win_slot

  ////////////////////////////////////////////////////////////////////////////
  ntar_pkg::ntar_state_t s_q;
  ntar_pkg::ntar_state_t s_d;

  logic [63:0] w [ntar_pkg::NUM_WIN];
  logic np_hit;
  logic pf_hit;
  logic opq_hit;
  logic up_hit;
  logic dn_np_hit;
  logic dn_pf_hit;
  logic dn_opq_hit;
  logic [31:0] io_mask;

  genvar gi;
  generate
    for (gi = 0; gi < ntar_pkg::NUM_WIN; gi++) begin : g_win
      assign w[gi] = s_q.win[gi];
    end
  endgenerate

  // offsets and derived limits are registered: compares can see two-cycle-old
  // values after a write, harmless since software sets windows up first
  assign np_hit = in_win(up_req_in.addr, w[ntar_pkg::W_NP_SEC_BASE],
                         s_q.np_sec_lim);
  assign pf_hit = in_win(up_req_in.addr, w[ntar_pkg::W_PF_SEC_BASE],
                         s_q.pf_sec_lim);
  assign opq_hit = s_q.opq_en &&
                   in_win(up_req_in.addr, w[ntar_pkg::W_OPQ_BASE],
                          w[ntar_pkg::W_OPQ_LIM]);
  assign up_hit = in_win(up_req_in.addr, w[ntar_pkg::W_UP_SEC_BASE],
                         w[ntar_pkg::W_UP_SEC_LIM]);
  assign dn_np_hit = in_win(dn_req_in.addr, w[ntar_pkg::W_NP_PRI_BASE],
                            w[ntar_pkg::W_NP_PRI_LIM]);
  assign dn_pf_hit = in_win(dn_req_in.addr, w[ntar_pkg::W_PF_PRI_BASE],
                            w[ntar_pkg::W_PF_PRI_LIM]);
  assign dn_opq_hit = s_q.opq_en &&
                      in_win(dn_req_in.addr, w[ntar_pkg::W_OPQ_BASE],
                             w[ntar_pkg::W_OPQ_LIM]);
  // io_drop upper bits are cleared; zero leaves all 32 bits
  assign io_mask = 32'hffff_ffff >> s_q.io_drop;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [4:0] slot;
    logic [31:0] rd;
    s_d = s_q;
    slot = win_slot(paddr_in);
    rd = ntar_pkg::RDATA_UNMAPPED;

    // derived windows, 64-bit wrapping
    s_d.np_off = w[ntar_pkg::W_NP_PRI_BASE] -
                 w[ntar_pkg::W_NP_SEC_BASE];
    s_d.pf_off = w[ntar_pkg::W_PF_PRI_BASE] -
                 w[ntar_pkg::W_PF_SEC_BASE];
    s_d.up_off = w[ntar_pkg::W_UP_PRI_BASE] -
                 w[ntar_pkg::W_UP_SEC_BASE];
    s_d.np_sec_lim = w[ntar_pkg::W_NP_PRI_LIM] - s_q.np_off;
    s_d.pf_sec_lim = w[ntar_pkg::W_PF_PRI_LIM] - s_q.pf_off;
    s_d.up_pri_lim = w[ntar_pkg::W_UP_SEC_LIM] + s_q.up_off;

    // apb: setup cycle, then access with pready one cycle later
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    if (psel_in && penable_in && !s_q.pready) begin
      s_d.pready = 1'b1;
      if (slot != 5'(ntar_pkg::NUM_WIN)) begin
        rd = paddr_in[2] ? s_q.win[slot][63:32] : s_q.win[slot][31:0];
        if (pwrite_in) begin
          if (paddr_in[2]) begin
            s_d.win[slot][63:32] = pwdata_in;
          end else begin
            s_d.win[slot][31:0] = pwdata_in;
          end
        end
      end else begin
        unique case (paddr_in)
          ntar_pkg::OFF_CTRL: begin
            rd = {31'h0, s_q.opq_en};
            if (pwrite_in) begin
              s_d.opq_en = pwdata_in[ntar_pkg::CTRL_OPQ_EN_BIT];
            end
          end
          ntar_pkg::OFF_IO_REMAP: begin
            rd = {27'h0, s_q.io_drop};
            if (pwrite_in) begin
              s_d.io_drop = pwdata_in[4:0];
            end
          end
          ntar_pkg::OFF_STATUS: begin
            rd = 32'h0;
            rd[ntar_pkg::ST_IO_ACTIVE_BIT] = |s_q.io_drop;
            rd[ntar_pkg::ST_OPQ_ACTIVE_BIT] = s_q.opq_en;
          end
          ntar_pkg::OFF_NP_SEC_LIM_LO: rd = s_q.np_sec_lim[31:0];
          ntar_pkg::OFF_NP_SEC_LIM_HI: rd = s_q.np_sec_lim[63:32];
          ntar_pkg::OFF_PF_SEC_LIM_LO: rd = s_q.pf_sec_lim[31:0];
          ntar_pkg::OFF_PF_SEC_LIM_HI: rd = s_q.pf_sec_lim[63:32];
          ntar_pkg::OFF_UP_PRI_LIM_LO: rd = s_q.up_pri_lim[31:0];
          ntar_pkg::OFF_UP_PRI_LIM_HI: rd = s_q.up_pri_lim[63:32];
          default: s_d.pslverr = 1'b1;
        endcase
      end
    end
    s_d.prdata = s_d.pready ? rd : ntar_pkg::RDATA_UNMAPPED;

    // upstream: pci -> pcie
    s_d.up_rsp.valid = up_req_in.valid;
    s_d.up_rsp.claim = up_req_in.valid && !np_hit && !pf_hit &&
                       !opq_hit;
    if (up_hit) begin
      s_d.up_rsp.addr = up_req_in.addr + s_q.up_off;
    end else begin
      s_d.up_rsp.addr = up_req_in.addr;
    end

    // downstream: pcie -> pci
    s_d.dn_rsp.valid = dn_req_in.valid;
    s_d.dn_rsp.claim = dn_req_in.valid && (dn_np_hit || dn_pf_hit) &&
                       !dn_opq_hit;
    if (dn_np_hit) begin
      s_d.dn_rsp.addr = dn_req_in.addr - s_q.np_off;
    end else if (dn_pf_hit) begin
      s_d.dn_rsp.addr = dn_req_in.addr - s_q.pf_off;
    end else begin
      s_d.dn_rsp.addr = dn_req_in.addr;
    end

    // io: no enable, a zero count is the identity
    s_d.io_rsp.valid = io_req_in.valid;
    s_d.io_rsp.addr = io_req_in.addr & io_mask;
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < ntar_pkg::NUM_WIN; i++) begin
        s_q.win[i] <= ntar_pkg::WIN_RST;
      end
      s_q.opq_en <= ntar_pkg::CTRL_RST[ntar_pkg::CTRL_OPQ_EN_BIT];
      s_q.io_drop <= ntar_pkg::IO_REMAP_RST;
      s_q.pready <= 1'b0;
      s_q.pslverr <= 1'b0;
      s_q.prdata <= ntar_pkg::RDATA_UNMAPPED;
      s_q.np_off <= ntar_pkg::WIN_RST;
      s_q.pf_off <= ntar_pkg::WIN_RST;
      s_q.up_off <= ntar_pkg::WIN_RST;
      s_q.np_sec_lim <= ntar_pkg::WIN_RST;
      s_q.pf_sec_lim <= ntar_pkg::WIN_RST;
      s_q.up_pri_lim <= ntar_pkg::WIN_RST;
      s_q.up_rsp <= '0;
      s_q.dn_rsp <= '0;
      s_q.io_rsp <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign prdata_out = s_q.prdata;
  assign pready_out = s_q.pready;
  assign pslverr_out = s_q.pslverr;
  assign up_rsp_out = s_q.up_rsp;
  assign dn_rsp_out = s_q.dn_rsp;
  assign io_rsp_out = s_q.io_rsp;

endmodule : ntar_remap

// File: ntar_remap_assertions.sv
`timescale 1ns/100ps
module ntar_remap_assertions (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // translation ports
  input ntar_pkg::ntar_req_t up_req_in,
  input ntar_pkg::ntar_rsp_t up_rsp_out,
  input ntar_pkg::ntar_req_t dn_req_in,
  input ntar_pkg::ntar_rsp_t dn_rsp_out,
  input ntar_pkg::ntar_io_req_t io_req_in,
  input ntar_pkg::ntar_io_rsp_t io_rsp_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  // rose, not level: the access stays high through the answer cycle
  sequence s_access;
    psel_in && $rose(penable_in);
  endsequence
  sequence s_pulse;
    pready_out ##1 !pready_out;
  endsequence
  a_apb_answer: assert property (s_access |=> s_pulse)
    else $error("apb answer late or long");
  a_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data outside answer");
  a_err_rdy: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  a_err_read0: assert property (pslverr_out && !pwrite_in |-> !prdata_out)
    else $error("unmapped read not zero");
  a_up_fwd: assert property (up_req_in.valid |=> up_rsp_out.valid)
    else $error("upstream answer missing");
  a_up_quiet: assert property (!up_req_in.valid |=> !up_rsp_out.valid)
    else $error("upstream answer unasked");
  a_dn_fwd: assert property (dn_req_in.valid |=> dn_rsp_out.valid)
    else $error("downstream answer missing");
  a_io_fwd: assert property (io_req_in.valid |=> io_rsp_out.valid)
    else $error("io answer missing");
  a_io_subset: assert property (io_rsp_out.valid |->
    (io_rsp_out.addr & ~$past(io_req_in.addr)) == 32'h0)
    else $error("io remap set a bit");
endmodule : ntar_remap_assertions

bind ntar_remap ntar_remap_assertions i_ntar_remap_assertions (
  .clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .up_req_in(up_req_in), .up_rsp_out(up_rsp_out), .dn_req_in(dn_req_in),
  .dn_rsp_out(dn_rsp_out), .io_req_in(io_req_in), .io_rsp_out(io_rsp_out)
);

// File: ntar_pci_agent.sv
`timescale 1ns/100ps
module ntar_pci_agent (
  // clock and command
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [63:0] addr_in,
  // memory cycle toward the bridge
  output ntar_pkg::ntar_req_t req_out
);
  ntar_pkg::ntar_req_t req_q = '0;
  // idle address flips so a stale value never passes for a live one
  always @(posedge clk_in) begin
    if (go_in) req_q <= '{1'b1, addr_in};
    else req_q <= '{1'b0, ~req_q.addr};
  end
  assign req_out = req_q;
endmodule : ntar_pci_agent

// File: nontransparent_addr_remap_tb_top.sv
`timescale 1ns/100ps
module nontransparent_addr_remap_tb_top;
  localparam logic [63:0] NPB = 64'h1_0000_0000, NPL = 64'h1_0fff_ffff;
  localparam logic [63:0] NPS = 64'h8000_0000, PFB = 64'h2_0000_0000;
  localparam logic [63:0] PFL = 64'h2_0fff_ffff, PFS = 64'ha000_0000;
  localparam logic [63:0] UPB = 64'h3_0000_0000, UPS = 64'h4000_0000;
  localparam logic [63:0] UPL = 64'h4fff_ffff, OPB = 64'h1_0800_0000;
  localparam logic [63:0] NPD = NPB - NPS, PFD = PFB - PFS, UPD = UPB - UPS;
  localparam logic [63:0] NSL = NPL - NPD, PSL = PFL - PFD, UPR = UPL + UPD;
  logic clk_in = '0, nrst_in = '0, psel_in = '0, penable_in = '0;
  logic pwrite_in = '0, go = '0, pready_out, pslverr_out, er;
  logic [7:0] paddr_in = '0;
  logic [31:0] pwdata_in = '0, prdata_out, rd, ia;
  logic [63:0] go_addr = '0, ra;
  logic [64:0] got;
  logic [64:0] expq[$];
  ntar_pkg::ntar_req_t up_req_in, dn_req_in = '0;
  ntar_pkg::ntar_rsp_t up_rsp_out, dn_rsp_out;
  ntar_pkg::ntar_io_req_t io_req_in = '0;
  ntar_pkg::ntar_io_rsp_t io_rsp_out;
  int errors = 0, samples_checked = 0, cyc = 0, seed = 9422;
  int ns[4] = '{0, 1, 16, 31};

  ntar_remap i_ntar_remap (.clk_in(clk_in), .nrst_in(nrst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .up_req_in(up_req_in), .up_rsp_out(up_rsp_out), .dn_req_in(dn_req_in),
    .dn_rsp_out(dn_rsp_out), .io_req_in(io_req_in), .io_rsp_out(io_rsp_out));
  ntar_pci_agent i_ntar_pci_agent (.clk_in(clk_in), .go_in(go),
    .addr_in(go_addr), .req_out(up_req_in));
  //////////////////////////////////////////////////////////////////////////
  initial forever #2.5 clk_in = ~clk_in;
  task end_sim;
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task chk(input logic [64:0] g, input logic [64:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // answer taken at the very edge that sees pready high, then released
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task w64(input logic [7:0] a, input logic [63:0] v);
    apb(1'b1, a, v[31:0]);
    apb(1'b1, a + 8'h04, v[63:32]);
  endtask : w64
  task rchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    chk({er, rd}, {ee, e});
  endtask : rchk
  task req(input int k, input logic [63:0] a, input logic [64:0] e);
    @(posedge clk_in);
    if (k == 0) begin
      go <= 1'b1;
      go_addr <= a;
    end else if (k == 1) dn_req_in <= '{1'b1, a};
    else io_req_in <= '{1'b1, a[31:0]};
    expq.push_back(e);
    @(posedge clk_in);
    go <= 1'b0;
    dn_req_in <= '{1'b0, ~a};
    io_req_in <= '{1'b0, ~a[31:0]};
  endtask : req
  always @(negedge clk_in) begin
    if (up_rsp_out.valid | dn_rsp_out.valid | io_rsp_out.valid) begin
      if (up_rsp_out.valid) got = {up_rsp_out.claim, up_rsp_out.addr};
      else if (dn_rsp_out.valid) got = {dn_rsp_out.claim, dn_rsp_out.addr};
      else got = {33'h1_0000_0000, io_rsp_out.addr};
      if (expq.size() == 0) chk(got, '1);
      else chk(got, expq.pop_front());
    end
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      $display("[FAIL] %0t timeout", $time);
      end_sim();
    end
  end
  initial begin
    repeat (8) @(posedge clk_in);
    nrst_in <= 1'b1;
    rchk(ntar_pkg::OFF_CTRL, 32'h0, 1'b0);
    rchk(8'hfc, 32'h0, 1'b1);
    w64(ntar_pkg::OFF_NP_PRI_BASE_LO, NPB);
    w64(ntar_pkg::OFF_NP_PRI_LIM_LO, NPL);
    w64(ntar_pkg::OFF_NP_SEC_BASE_LO, NPS);
    w64(ntar_pkg::OFF_PF_PRI_BASE_LO, PFB);
    w64(ntar_pkg::OFF_PF_PRI_LIM_LO, PFL);
    w64(ntar_pkg::OFF_PF_SEC_BASE_LO, PFS);
    w64(ntar_pkg::OFF_UP_PRI_BASE_LO, UPB);
    w64(ntar_pkg::OFF_UP_SEC_BASE_LO, UPS);
    w64(ntar_pkg::OFF_UP_SEC_LIM_LO, UPL);
    w64(ntar_pkg::OFF_OPQ_BASE_LO, OPB);
    w64(ntar_pkg::OFF_OPQ_LIM_LO, OPB + 64'hff);
    apb(1'b1, ntar_pkg::OFF_NP_SEC_LIM_LO, 32'hffff_ffff);
    chk(er, 1'b0);
    rchk(ntar_pkg::OFF_NP_SEC_LIM_LO, NSL[31:0], 1'b0);
    rchk(ntar_pkg::OFF_PF_SEC_LIM_HI, PSL[63:32], 1'b0);
    rchk(ntar_pkg::OFF_UP_PRI_LIM_HI, UPR[63:32], 1'b0);
    rchk(ntar_pkg::OFF_UP_PRI_LIM_LO, UPR[31:0], 1'b0);
    $display("test config done");
    req(1, NPB, {1'b1, NPB - NPD});
    req(1, NPL, {1'b1, NPL - NPD});
    req(1, PFB + 64'h5, {1'b1, PFB + 64'h5 - PFD});
    req(1, 64'h5_0000_0000, {1'b0, 64'h5_0000_0000});
    req(0, NPS, {1'b0, NPS});
    req(0, NSL, {1'b0, NSL});
    req(0, NSL + 64'h1, {1'b1, NSL + 64'h1});
    req(0, PSL, {1'b0, PSL});
    req(0, UPS, {1'b1, UPS + UPD});
    req(0, UPL, {1'b1, UPL + UPD});
    req(0, UPL + 64'h1, {1'b1, UPL + 64'h1});
    req(0, OPB, {1'b1, OPB});
    for (int i = 0; i < 16; i++) begin
      ra = {16'h0001, 16'($random(seed)), 32'($random(seed))};
      req(0, ra, {1'b1, ra});
    end
    $display("test memory done");
    apb(1'b1, ntar_pkg::OFF_CTRL, 32'h1);
    repeat (3) @(posedge clk_in);
    req(0, OPB + 64'hff, {1'b0, OPB + 64'hff});
    req(1, OPB, {1'b0, OPB - NPD});
    foreach (ns[i]) begin
      apb(1'b1, ntar_pkg::OFF_IO_REMAP, 32'(ns[i]));
      rchk(ntar_pkg::OFF_STATUS, 32'h2 | 32'(ns[i] != 0), 1'b0);
      ia = $random(seed);
      req(2, {32'h0, ia},
          {33'h1_0000_0000, ia & (32'hffff_ffff >> ns[i])});
    end
    $display("test opaque and io done");
    repeat (4) @(posedge clk_in);
    // a note left behind means an answer never came
    if (expq.size() != 0) begin
      errors++;
      $display("[FAIL] %0t %0d answers missing", $time, expq.size());
    end
    end_sim();
  end
endmodule : nontransparent_addr_remap_tb_top
